// [dv/motion_window_monitor_test.sv]
`timescale 1ns/10ps
// Self-checking bench: object accesses plus motion stimulus against status timing.
module motion_window_monitor_test;
    localparam int TD = 4;
    logic                 clk_sys;
    logic                 reset_n;
    logic                 clk_en;
    mwm_pkg::mwm_req_t    obj_req;
    mwm_pkg::mwm_rsp_t    obj_rsp;
    mwm_pkg::mwm_motion_t motion;
    logic [15:0]          drive_status_word;
    logic                 fault_reaction_pulse;
    logic [15:0]          fault_reaction_code;
    logic                 error_history_push;
    int                   failures;
    int                   checked;
    int                   pulses;
    int                   pushes;
    logic [15:0]          rix [11] = '{16'h6066, 16'h6067, 16'h6068, 16'h606B, 16'h606C,
                                       16'h606D, 16'h606E, 16'h606F, 16'h6065, 16'h6070, 16'h3700};
    logic [31:0]          rrv [11] = '{32'h64, 32'hA, 32'h64, 32'h0, 32'h0, 32'h1E, 32'h0,
                                       32'h0, 32'h100, 32'h0, 32'h0};

    // System clock at 25 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    mwm_top #(.TICK_DIV(TD)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .obj_req(obj_req),
        .obj_rsp(obj_rsp), .motion(motion), .drive_status_word(drive_status_word),
        .fault_reaction_pulse(fault_reaction_pulse), .fault_reaction_code(fault_reaction_code),
        .error_history_push(error_history_push)
    );

    mwm_master u_master (.clk_sys(clk_sys), .obj_rsp(obj_rsp), .obj_req(obj_req));

    // Counts reaction and history pulses as the device raises them.
    always @(posedge clk_sys) begin
        pulses += (fault_reaction_pulse === 1'b1);
        pushes += (error_history_push === 1'b1);
    end

    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        checked++;
        if (sn !== ex) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic wr(input logic [15:0] ix, input logic [31:0] d, input logic ee);
        logic        e;
        logic [31:0] r;
        u_master.access(1'b1, ix, d, e, r);
        check($sformatf("write error %h", ix), {31'h0, ee}, {31'h0, e});
    endtask

    task automatic rd(input logic [15:0] ix, input logic [31:0] ex, input logic ee);
        logic        e;
        logic [31:0] r;
        u_master.access(1'b0, ix, 32'h0, e, r);
        check($sformatf("read error %h", ix), {31'h0, ee}, {31'h0, e});
        check($sformatf("object %h", ix), ex, r);
    endtask

    // Waits for a status bit; persistence L gives the window, L below zero means at once.
    task automatic settle(input int b, input logic v, input int l);
        int n;
        n = 0;
        while (drive_status_word[b] !== v && n <= (l + 1) * TD + 3) begin
            @(negedge clk_sys);
            n++;
        end
        checked++;
        if (n < l * TD + 2 || n > (l + 1) * TD + 3) begin
            failures++;
            $display("unexpected status bit %0d delay: expected %0d to %0d seen %0d",
                     b, l * TD + 2, (l + 1) * TD + 3, n);
        end
    endtask

    task automatic hold(input int b, input logic v);
        repeat (20) begin
            @(negedge clk_sys);
            check($sformatf("status bit %0d", b), {31'h0, v}, {31'h0, drive_status_word[b]});
        end
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the few hundred cycles the tests take.
    initial begin
        #(40 * 20000);
        failures++;
        complete_run();
    end

    // Main sequence of object accesses and motion scenarios.
    initial begin
        failures = 0;
        checked = 0;
        pulses = 0;
        pushes = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        motion = '0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        check("status after reset", 32'h1000, {16'h0, drive_status_word});
        for (int i = 0; i < 11; i++) rd(rix[i], rrv[i], 1'b0);
        for (int i = 0; i < 11; i++) begin
            wr(rix[i], 32'hA5A55A5A, i inside {3, 4});
            rd(rix[i], (i inside {3, 4}) ? 32'h0 : (i inside {1, 8}) ? 32'hA5A55A5A
               : 32'h5A5A, 1'b0);
        end
        rd(16'h6000, 32'h0, 1'b1);
        motion.vel_ramp = 32'h12345678;
        motion.vel_actual = 32'h111;
        rd(16'h606B, 32'h12345678, 1'b0);
        rd(16'h606C, 32'h111, 1'b0);
        // Following error: limit 10, timeout 3 ms, reaction code 2.
        wr(16'h6065, 32'hA, 1'b0);
        wr(16'h6066, 32'h3, 1'b0);
        wr(16'h3700, 32'h2, 1'b0);
        motion.pos_actual = 32'h0B;
        settle(13, 1'b1, 3);
        // The pulse counter samples the pulse at the next rising edge.
        @(negedge clk_sys);
        check("reaction pulses", 32'h1, pulses);
        check("history pushes", 32'h1, pushes);
        check("reaction code", 32'h2, {16'h0, fault_reaction_code});
        motion.pos_actual = 32'h0A;
        settle(13, 1'b0, -1);
        motion.pos_actual = 32'hFFFFFFF5;
        settle(13, 1'b1, 3);
        wr(16'h6065, 32'hFFFFFFFF, 1'b0);
        settle(13, 1'b0, -1);
        hold(13, 1'b0);
        check("reaction pulses", 32'h2, pulses);
        // Position window: 5 units, 2 ms.
        motion.pos_actual = 32'h0;
        wr(16'h6067, 32'h5, 1'b0);
        wr(16'h6068, 32'h2, 1'b0);
        motion.pos_target = 32'h3E8;
        motion.pos_actual = 32'h3ED;
        motion.mode = 8'h01;
        hold(10, 1'b0);
        motion.pos_actual = 32'h3E4;
        settle(10, 1'b1, 2);
        motion.pos_actual = 32'h3F2;
        settle(10, 1'b0, -1);
        motion.mode = 8'h07;
        motion.pos_actual = 32'h3EC;
        settle(10, 1'b1, 2);
        motion.mode = 8'h04;
        settle(10, 1'b0, -1);
        hold(10, 1'b0);
        wr(16'h6067, 32'hFFFFFFFF, 1'b0);
        motion.mode = 8'h01;
        hold(10, 1'b0);
        // Velocity window: 20 units, 1 ms, in profile velocity.
        wr(16'h606D, 32'h14, 1'b0);
        wr(16'h606E, 32'h1, 1'b0);
        wr(16'h606F, 32'h258, 1'b0);
        wr(16'h6070, 32'h2, 1'b0);
        motion.vel_target = 32'h1F4;
        motion.vel_actual = 32'h207;
        motion.mode = 8'h03;
        settle(10, 1'b1, 1);
        motion.vel_actual = 32'h208;
        settle(10, 1'b0, -1);
        motion.vel_actual = 32'h1E1;
        settle(10, 1'b1, 1);
        // Speed threshold 600 units held 2 ms.
        motion.vel_actual = 32'h258;
        hold(12, 1'b1);
        motion.vel_actual = 32'h259;
        settle(12, 1'b0, 2);
        motion.vel_actual = 32'h64;
        settle(12, 1'b1, -1);
        motion.mode = 8'h01;
        motion.vel_actual = 32'h2BC;
        hold(12, 1'b1);
        // With the clock enable low the status word stays frozen.
        clk_en = 1'b0;
        motion.mode = 8'h03;
        hold(12, 1'b1);
        clk_en = 1'b1;
        settle(12, 1'b0, 2);
        // A second reset restores the preset values.
        reset_n = 1'b0;
        @(negedge clk_sys);
        reset_n = 1'b1;
        check("status after reset", 32'h1000, {16'h0, drive_status_word});
        rd(16'h6067, 32'hA, 1'b0);
        complete_run();
    end
endmodule

// [dv/mwm_master.sv]
`timescale 1ns/10ps
// Fieldbus master model: one object access at a time, answer taken from the one-cycle reply.
module mwm_master (
    input  wire logic              clk_sys,
    input  wire mwm_pkg::mwm_rsp_t obj_rsp,
    output mwm_pkg::mwm_req_t      obj_req
);
    // The request lines stay idle until a task drives them.
    initial obj_req = '0;

    // Request stands for exactly the edge that takes it; a missing reply returns unknowns.
    task automatic access(input logic wr, input logic [15:0] ix, input logic [31:0] wd,
                          output logic err, output logic [31:0] rd);
        int n;
        @(negedge clk_sys);
        obj_req = '{valid: 1'b1, write: wr, index: ix, wdata: wd};
        @(negedge clk_sys);
        obj_req = '{valid: 1'b0, write: ~wr, index: ~ix, wdata: ~wd};
        n = 0;
        while (obj_rsp.valid !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        err = (n < 4) ? obj_rsp.error : 1'bx;
        rd  = (n < 4) ? obj_rsp.rdata : 'x;
    endtask
endmodule

// [dv/mwm_top_asserts.sv]
`timescale 1ns/10ps
// Watches the object bus and the status outputs of the monitor top.
module mwm_top_asserts #(
    parameter int TICK_DIV = 4
) (
    input wire logic                 clk_sys,
    input wire logic                 reset_n,
    input wire logic                 clk_en,
    input wire mwm_pkg::mwm_req_t    obj_req,
    input wire mwm_pkg::mwm_rsp_t    obj_rsp,
    input wire mwm_pkg::mwm_motion_t motion,
    input wire logic [15:0]          drive_status_word,
    input wire logic                 fault_reaction_pulse,
    input wire logic [15:0]          fault_reaction_code,
    input wire logic                 error_history_push
);
    // All checks run on the system clock and rest during reset.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    rsp_answer_a: assert property (clk_en && obj_req.valid |=> obj_rsp.valid)
        else $error("object request without reply");
    ro_refuse_a: assert property (clk_en && obj_req.valid && obj_req.write
        && obj_req.index == mwm_pkg::IDX_VELOCITY_DEMAND_VALUE |=> obj_rsp.error)
        else $error("write to demand value accepted");
    // The demand value passes a capture register before the reply register.
    demand_read_a: assert property (
        clk_en && obj_req.valid && !obj_req.write
        && obj_req.index == mwm_pkg::IDX_VELOCITY_DEMAND_VALUE
        |=> obj_rsp.rdata == $past(motion.vel_ramp, 2))
        else $error("demand value differs from ramp output");
    fault_pair_a: assert property (fault_reaction_pulse == error_history_push)
        else $error("history push not paired with reaction");
    fault_code_a: assert property (fault_reaction_pulse |-> fault_reaction_code != 16'h0000)
        else $error("reaction fired with no reaction selected");
    pulse_single_a: assert property (fault_reaction_pulse |=> !fault_reaction_pulse)
        else $error("reaction pulse longer than one cycle");
    fe_bit_a: assert property (fault_reaction_pulse |-> ##[0:2] drive_status_word[13])
        else $error("reaction without following error bit");
    fe_idle_a: assert property ((motion.pos_actual == motion.pos_demand)[*3]
        |=> !drive_status_word[13])
        else $error("following error bit with zero deviation");
    spd_idle_a: assert property ((motion.mode != mwm_pkg::MODE_PROFILE_VELOCITY
        || $signed(motion.vel_actual) <= 0)[*3] |=> drive_status_word[12])
        else $error("speed bit low outside fast profile velocity");
    pos_mode_a: assert property ((!(motion.mode inside {8'h01, 8'h03, 8'h07}))[*3]
        |=> !drive_status_word[10])
        else $error("target bit set in unmonitored mode");
endmodule

bind mwm_top mwm_top_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .obj_req(obj_req),
    .obj_rsp(obj_rsp), .motion(motion), .drive_status_word(drive_status_word),
    .fault_reaction_pulse(fault_reaction_pulse), .fault_reaction_code(fault_reaction_code),
    .error_history_push(error_history_push)
);

// [rtl/mwm_persist.sv]
`timescale 1ns/10ps
// Persistence timer: the output rises once the condition has held for more
// than limit milliseconds, and falls as soon as the condition drops.
module mwm_persist #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic         tick,
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    output logic              hit
);
    logic [W:0] cnt_q;

    // Count milliseconds while the condition holds; restart when it drops.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (!cond) begin
                cnt_q <= '0;
            end else if (tick && cnt_q <= {1'b0, limit}) begin
                cnt_q <= cnt_q + (W+1)'(1);
            end
        end
    end

    // The flag is set only after strictly more than limit ticks.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hit <= 1'b0;
        end else if (clk_en) begin
            hit <= cond && (cnt_q > {1'b0, limit});
        end
    end
endmodule

// [rtl/mwm_pkg.sv]
package mwm_pkg;

    // Object dictionary indices of the configuration and value objects.
    localparam logic [15:0] IDX_FOLLOWING_ERROR_TIMEOUT = 16'h6066;
    localparam logic [15:0] IDX_POSITION_WINDOW         = 16'h6067;
    localparam logic [15:0] IDX_POSITION_WINDOW_TIME    = 16'h6068;
    localparam logic [15:0] IDX_VELOCITY_DEMAND_VALUE   = 16'h606B;
    localparam logic [15:0] IDX_VELOCITY_ACTUAL_VALUE   = 16'h606C;
    localparam logic [15:0] IDX_VELOCITY_WINDOW         = 16'h606D;
    localparam logic [15:0] IDX_VELOCITY_WINDOW_TIME    = 16'h606E;
    localparam logic [15:0] IDX_VELOCITY_THRESHOLD      = 16'h606F;
    localparam logic [15:0] IDX_FOLLOWING_ERROR_LIMIT   = 16'h6065;
    localparam logic [15:0] IDX_THRESHOLD_HOLD_TIME     = 16'h6070;
    localparam logic [15:0] IDX_FAULT_REACTION_SELECT   = 16'h3700;

    // Reset values of the writable objects.
    localparam logic [15:0] RST_FOLLOWING_ERROR_TIMEOUT = 16'h0064;
    localparam logic [31:0] RST_POSITION_WINDOW         = 32'h0000000A;
    localparam logic [15:0] RST_POSITION_WINDOW_TIME    = 16'h0064;
    localparam logic [15:0] RST_VELOCITY_WINDOW         = 16'h001E;
    localparam logic [15:0] RST_VELOCITY_WINDOW_TIME    = 16'h0000;
    localparam logic [15:0] RST_VELOCITY_THRESHOLD      = 16'h0000;
    localparam logic [31:0] RST_FOLLOWING_ERROR_LIMIT   = 32'h00000100;
    localparam logic [15:0] RST_THRESHOLD_HOLD_TIME     = 16'h0000;
    localparam logic [15:0] RST_FAULT_REACTION_SELECT   = 16'h0000;

    // Value that switches a window monitor off.
    localparam logic [31:0] WINDOW_OFF = 32'hFFFFFFFF;

    // Drive status word bit positions.
    localparam int STS_TARGET_REACHED  = 10;
    localparam int STS_SPEED_ZERO      = 12;
    localparam int STS_FOLLOWING_ERROR = 13;

    // Operating mode codes.
    localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
    localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
    localparam logic [7:0] MODE_INTERP_POSITION  = 8'h07;

    // Millisecond tick timing.
    localparam int CLK_HZ        = 25000000;
    localparam int TICK_MS       = 1;
    localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

    // Object access request from the fieldbus side.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [31:0] wdata;
    } mwm_req_t;

    // Object access answer.
    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] rdata;
    } mwm_rsp_t;

    // Motion values sampled from the control loops.
    typedef struct packed {
        logic [31:0] pos_actual;
        logic [31:0] pos_demand;
        logic [31:0] pos_target;
        logic [31:0] vel_actual;
        logic [31:0] vel_target;
        logic [31:0] vel_ramp;
        logic [7:0]  mode;
    } mwm_motion_t;

endpackage

// [rtl/mwm_top.sv]
`timescale 1ns/10ps
// How it works
// - Status bit 13 on excessive following error.
// - Following error needs persistence beyond timeout.
// - Timeout is a 16-bit millisecond count.
// - Configured fault reaction fires on following error.
// - Triggered reaction also logs an error entry.
// - Status bit 10 when position within window.
// - Position check only in position modes.
// - Position must stay inside window time.
// - All-ones position window disables monitoring.
// - Status bit 10 when speed within window.
// - Speed must stay inside velocity window time.
// - Bit 12 low when speed above threshold.
// - Threshold check only in profile velocity.
// - Velocity demand shows ramp generator output.
// - All-ones following limit disables monitoring.
// - Threshold hold time counts milliseconds.
module mwm_top #(
    parameter int TICK_DIV = mwm_pkg::TICK_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire mwm_pkg::mwm_req_t    obj_req,
    output mwm_pkg::mwm_rsp_t         obj_rsp,
    input  wire mwm_pkg::mwm_motion_t motion,
    output logic [15:0]               drive_status_word,
    output logic                      fault_reaction_pulse,
    output logic [15:0]               fault_reaction_code,
    output logic                      error_history_push
);
    logic [15:0] following_error_timeout_q;
    logic [31:0] position_window_q;
    logic [15:0] position_window_time_q;
    logic [15:0] velocity_window_q;
    logic [15:0] velocity_window_time_q;
    logic [15:0] velocity_threshold_q;
    logic [31:0] following_error_limit_q;
    logic [15:0] velocity_threshold_hold_time_q;
    logic [15:0] fault_reaction_select_q;
    logic [31:0] velocity_demand_q;
    logic [31:0] velocity_actual_q;
    logic [31:0] tick_cnt_q;
    logic        tick_q;
    logic        ferr_cond;
    logic        pos_cond;
    logic        vel_cond;
    logic        spd_cond;
    logic        ferr_hit;
    logic        pos_hit;
    logic        vel_hit;
    logic        spd_hit;
    logic        ferr_hit_prev_q;
    logic        pos_mode;
    logic        vel_mode;

    // Magnitude of the signed difference of two 32-bit values.
    function automatic logic [32:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic signed [32:0] d;
        d = $signed({a[31], a}) - $signed({b[31], b});
        abs_diff = d[32] ? 33'(-d) : 33'(d);
    endfunction

    // Millisecond tick divider.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (clk_en) begin
            if (tick_cnt_q == 32'(TICK_DIV - 1)) begin
                tick_cnt_q <= '0;
                tick_q     <= 1'b1;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h1;
                tick_q     <= 1'b0;
            end
        end
    end

    // Writable objects; writes to read-only or unknown indices are refused.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            following_error_timeout_q      <= mwm_pkg::RST_FOLLOWING_ERROR_TIMEOUT;
            position_window_q              <= mwm_pkg::RST_POSITION_WINDOW;
            position_window_time_q         <= mwm_pkg::RST_POSITION_WINDOW_TIME;
            velocity_window_q              <= mwm_pkg::RST_VELOCITY_WINDOW;
            velocity_window_time_q         <= mwm_pkg::RST_VELOCITY_WINDOW_TIME;
            velocity_threshold_q           <= mwm_pkg::RST_VELOCITY_THRESHOLD;
            following_error_limit_q        <= mwm_pkg::RST_FOLLOWING_ERROR_LIMIT;
            velocity_threshold_hold_time_q <= mwm_pkg::RST_THRESHOLD_HOLD_TIME;
            fault_reaction_select_q        <= mwm_pkg::RST_FAULT_REACTION_SELECT;
        end else if (clk_en && obj_req.valid && obj_req.write) begin
            case (obj_req.index)
                mwm_pkg::IDX_FOLLOWING_ERROR_TIMEOUT: begin
                    following_error_timeout_q <= obj_req.wdata[15:0];
                end
                mwm_pkg::IDX_POSITION_WINDOW: begin
                    position_window_q <= obj_req.wdata;
                end
                mwm_pkg::IDX_POSITION_WINDOW_TIME: begin
                    position_window_time_q <= obj_req.wdata[15:0];
                end
                mwm_pkg::IDX_VELOCITY_WINDOW: begin
                    velocity_window_q <= obj_req.wdata[15:0];
                end
                mwm_pkg::IDX_VELOCITY_WINDOW_TIME: begin
                    velocity_window_time_q <= obj_req.wdata[15:0];
                end
                mwm_pkg::IDX_VELOCITY_THRESHOLD: begin
                    velocity_threshold_q <= obj_req.wdata[15:0];
                end
                mwm_pkg::IDX_FOLLOWING_ERROR_LIMIT: begin
                    following_error_limit_q <= obj_req.wdata;
                end
                mwm_pkg::IDX_THRESHOLD_HOLD_TIME: begin
                    velocity_threshold_hold_time_q <= obj_req.wdata[15:0];
                end
                mwm_pkg::IDX_FAULT_REACTION_SELECT: begin
                    fault_reaction_select_q <= obj_req.wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Object answers: one cycle after the request, unknown index or a write
    // to a read-only object answers with error set.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            obj_rsp <= '0;
        end else if (clk_en) begin
            obj_rsp.valid <= obj_req.valid;
            obj_rsp.error <= 1'b0;
            obj_rsp.rdata <= '0;
            if (obj_req.valid) begin
                case (obj_req.index)
                    mwm_pkg::IDX_FOLLOWING_ERROR_TIMEOUT: begin
                        obj_rsp.rdata <= {16'h0000, following_error_timeout_q};
                    end
                    mwm_pkg::IDX_POSITION_WINDOW: begin
                        obj_rsp.rdata <= position_window_q;
                    end
                    mwm_pkg::IDX_POSITION_WINDOW_TIME: begin
                        obj_rsp.rdata <= {16'h0000, position_window_time_q};
                    end
                    mwm_pkg::IDX_VELOCITY_DEMAND_VALUE: begin
                        obj_rsp.rdata <= velocity_demand_q;
                        obj_rsp.error <= obj_req.write;
                    end
                    mwm_pkg::IDX_VELOCITY_ACTUAL_VALUE: begin
                        obj_rsp.rdata <= velocity_actual_q;
                        obj_rsp.error <= obj_req.write;
                    end
                    mwm_pkg::IDX_VELOCITY_WINDOW: begin
                        obj_rsp.rdata <= {16'h0000, velocity_window_q};
                    end
                    mwm_pkg::IDX_VELOCITY_WINDOW_TIME: begin
                        obj_rsp.rdata <= {16'h0000, velocity_window_time_q};
                    end
                    mwm_pkg::IDX_VELOCITY_THRESHOLD: begin
                        obj_rsp.rdata <= {16'h0000, velocity_threshold_q};
                    end
                    mwm_pkg::IDX_FOLLOWING_ERROR_LIMIT: begin
                        obj_rsp.rdata <= following_error_limit_q;
                    end
                    mwm_pkg::IDX_THRESHOLD_HOLD_TIME: begin
                        obj_rsp.rdata <= {16'h0000, velocity_threshold_hold_time_q};
                    end
                    mwm_pkg::IDX_FAULT_REACTION_SELECT: begin
                        obj_rsp.rdata <= {16'h0000, fault_reaction_select_q};
                    end
                    default: begin
                        obj_rsp.error <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Captured speed values shown as read-only objects.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            velocity_demand_q <= '0;
            velocity_actual_q <= '0;
        end else if (clk_en) begin
            velocity_demand_q <= motion.vel_ramp;
            velocity_actual_q <= motion.vel_actual;
        end
    end

    // Window conditions and operating mode qualifiers.
    assign pos_mode  = (motion.mode == mwm_pkg::MODE_PROFILE_POSITION)
                    || (motion.mode == mwm_pkg::MODE_INTERP_POSITION);
    assign vel_mode  = (motion.mode == mwm_pkg::MODE_PROFILE_VELOCITY);
    assign ferr_cond = (following_error_limit_q != mwm_pkg::WINDOW_OFF)
                    && (abs_diff(motion.pos_actual, motion.pos_demand)
                        > {1'b0, following_error_limit_q});
    assign pos_cond  = pos_mode && (position_window_q != mwm_pkg::WINDOW_OFF)
                    && (abs_diff(motion.pos_actual, motion.pos_target)
                        < {1'b0, position_window_q});
    assign vel_cond  = vel_mode
                    && (abs_diff(motion.vel_actual, motion.vel_target)
                        < {17'h00000, velocity_window_q});
    assign spd_cond  = vel_mode
                    && ($signed(motion.vel_actual)
                        > $signed({16'h0000, velocity_threshold_q}));

    // Persistence timer for the following error.
    mwm_persist #(.W(16)) u_ferr (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (tick_q),
        .cond    (ferr_cond),
        .limit   (following_error_timeout_q),
        .hit     (ferr_hit)
    );

    // Persistence timer for the position window.
    mwm_persist #(.W(16)) u_pos (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (tick_q),
        .cond    (pos_cond),
        .limit   (position_window_time_q),
        .hit     (pos_hit)
    );

    // Persistence timer for the velocity window.
    mwm_persist #(.W(16)) u_vel (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (tick_q),
        .cond    (vel_cond),
        .limit   (velocity_window_time_q),
        .hit     (vel_hit)
    );

    // Persistence timer for speed above threshold.
    mwm_persist #(.W(16)) u_spd (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (tick_q),
        .cond    (spd_cond),
        .limit   (velocity_threshold_hold_time_q),
        .hit     (spd_hit)
    );

    // Drive status word assembly; other bits read as zero.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drive_status_word <= 16'h1000;
        end else if (clk_en) begin
            drive_status_word <= '0;
            drive_status_word[mwm_pkg::STS_FOLLOWING_ERROR] <= ferr_hit;
            drive_status_word[mwm_pkg::STS_TARGET_REACHED]  <= pos_hit || vel_hit;
            drive_status_word[mwm_pkg::STS_SPEED_ZERO]      <= !spd_hit;
        end
    end

    // Fault reaction and error history entry on the rising following error.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ferr_hit_prev_q      <= 1'b0;
            fault_reaction_pulse <= 1'b0;
            fault_reaction_code  <= '0;
            error_history_push   <= 1'b0;
        end else if (clk_en) begin
            ferr_hit_prev_q      <= ferr_hit;
            fault_reaction_pulse <= 1'b0;
            error_history_push   <= 1'b0;
            if (ferr_hit && !ferr_hit_prev_q && fault_reaction_select_q != 16'h0000) begin
                fault_reaction_pulse <= 1'b1;
                fault_reaction_code  <= fault_reaction_select_q;
                error_history_push   <= 1'b1;
            end
        end
    end
endmodule
